/* hdl/arp_attr_regs.sv */
`timescale 1ns/100ps
module arp_attr_regs
  import arp_pkg::*;
#(
  parameter int NUM_PAL = 16
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire arp_io_s    io,
  input  wire logic       monoEmulation,
  input  wire logic [3:0] pixelValue,
  output logic      [7:0] rdData,
  output logic            rdValid,
  output logic            videoEnable,
  output logic      [7:0] colorIndexBits,
  output logic      [7:0] modeControl,
  output logic      [7:0] borderColor,
  output logic      [7:0] planeEnable,
  output logic      [7:0] horizontalPan
);
  arp_ff_e     ffState_reg;
  arp_ff_e     ffState_next;
  logic [7:0]  index_reg;
  logic [7:0]  palette_reg [NUM_PAL];
  logic [7:0]  colorSelect_reg;
  logic [7:0]  rdData_reg;
  logic        rdValid_reg;
  logic [7:0]  colorIndex_reg;

  wire logic        wrShared;
  wire logic        rdShared;
  wire logic        rdData_port;
  wire logic        rdStatus;
  wire logic [15:0] statusPort;
  wire logic        wrIndex;
  wire logic        wrData;
  wire logic [4:0]  selIdx;
  wire logic        palOpen;
  wire logic        selPal;
  wire logic        selValid;
  wire logic [7:0]  dataMux;
  wire logic [7:0]  rdNext;
  wire logic [7:0]  mappedColor;
  wire arp_colsel_s colSel;

  function automatic logic isPal(input logic [4:0] idx);
    isPal = (idx <= IDX_PAL_LAST);
  endfunction : isPal

  // the flip-flop reset address tracks the emulation strap
  assign statusPort  = monoEmulation ? PORT_STAT_MONO : PORT_STAT_CLR;
  assign wrShared    = io.wr && (io.addr == PORT_SHARED);
  assign rdShared    = io.rd && (io.addr == PORT_SHARED);
  assign rdData_port = io.rd && (io.addr == PORT_DATA_RD);
  assign rdStatus    = io.rd && (io.addr == statusPort);
  assign wrIndex     = wrShared && (ffState_reg == FF_INDEX);
  assign wrData      = wrShared && (ffState_reg == FF_DATA);
  assign selIdx      = index_reg[4:0];
  assign palOpen     = !index_reg[IDX_VIDEO_BIT];
  assign selPal      = isPal(selIdx);
  assign selValid    = selIdx <= IDX_COLSEL;

  // a status read wins over a simultaneous shared write: bus is not one-hot
  always_comb begin
    ffState_next = ffState_reg;
    if (rdStatus) begin
      ffState_next = FF_INDEX;
    end else if (wrShared) begin
      ffState_next = arp_ff_e'(~ffState_reg);
    end
  end

  assign dataMux =
    (selPal && palOpen)      ? palette_reg[selIdx[3:0]] :
    (selIdx == IDX_MODE)     ? modeControl :
    (selIdx == IDX_BORDER)   ? borderColor :
    (selIdx == IDX_PLANE)    ? planeEnable :
    (selIdx == IDX_PAN)      ? horizontalPan :
    (selIdx == IDX_COLSEL)   ? colorSelect_reg :
                               READ_ZERO;
  assign rdNext = rdShared ? index_reg : dataMux;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ffState_reg <= FF_INDEX;
    end else begin
      ffState_reg <= ffState_next;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      index_reg <= RESET_VAL;
    end else if (wrIndex) begin
      index_reg <= io.wdata & IDX_WR_MASK;
    end
  end

  // palette locked while video is on, so scan-out never sees a torn entry
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAL; gi++) begin : gPal
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          palette_reg[gi] <= RESET_VAL;
        end else if (wrData && palOpen && selIdx == 5'(gi)) begin
          palette_reg[gi] <= io.wdata & PAL_MASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      modeControl     <= RESET_VAL;
      borderColor     <= RESET_VAL;
      planeEnable     <= RESET_VAL;
      horizontalPan   <= RESET_VAL;
      colorSelect_reg <= RESET_VAL;
    end else if (wrData && selValid) begin
      if (selIdx == IDX_MODE)   modeControl     <= io.wdata;
      if (selIdx == IDX_BORDER) borderColor     <= io.wdata;
      if (selIdx == IDX_PLANE)  planeEnable     <= io.wdata;
      if (selIdx == IDX_PAN)    horizontalPan   <= io.wdata;
      if (selIdx == IDX_COLSEL) colorSelect_reg <= io.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData_reg  <= RESET_VAL;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= rdShared || rdData_port;
      if (rdShared || rdData_port) begin
        rdData_reg <= rdNext;
      end
    end
  end
  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

  assign colSel.top     = colorSelect_reg[3:2];
  assign colSel.subst   = colorSelect_reg[1:0];
  assign colSel.substEn = modeControl[MODE_SUBST_BIT];

  arp_palette_map u_map (
    .entry      (palette_reg[pixelValue][5:0]),
    .sel        (colSel),
    .colorIndex (mappedColor)
  );

  // blanked output while host owns the palette
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      colorIndex_reg <= RESET_VAL;
      videoEnable    <= 1'b0;
    end else begin
      videoEnable    <= !palOpen;
      colorIndex_reg <= palOpen ? RESET_VAL : mappedColor;
    end
  end
  assign colorIndexBits = colorIndex_reg;

  sequence s_idxWrite;
    wrIndex;
  endsequence

  a_ff_toggle: assert property (@(posedge clk_sys) disable iff (reset)
    wrShared && !rdStatus |=> ffState_reg != $past(ffState_reg))
    else $error("flip-flop did not toggle on shared write");
  a_status_reset: assert property (@(posedge clk_sys) disable iff (reset)
    rdStatus |=> ffState_reg == FF_INDEX)
    else $error("status read did not force index state");
  a_emul_addr: assert property (@(posedge clk_sys) disable iff (reset)
    io.rd && io.addr == PORT_STAT_CLR && monoEmulation && !wrShared
    |=> ffState_reg == $past(ffState_reg))
    else $error("wrong emulation address reset flip-flop");
  a_dataread_keep: assert property (@(posedge clk_sys) disable iff (reset)
    rdData_port && !wrShared |=> $stable(ffState_reg))
    else $error("data read disturbed flip-flop");
  a_index_load: assert property (@(posedge clk_sys) disable iff (reset)
    s_idxWrite |=> index_reg == ($past(io.wdata) & IDX_WR_MASK))
    else $error("index not loaded");
  a_index_rdback: assert property (@(posedge clk_sys) disable iff (reset)
    rdShared |=> rdValid && rdData == $past(index_reg))
    else $error("index readback wrong");
  a_hi_idx_zero: assert property (@(posedge clk_sys) disable iff (reset)
    rdData_port && !selValid |=> rdData == READ_ZERO)
    else $error("high index did not read zero");
  a_pal_locked: assert property (@(posedge clk_sys) disable iff (reset)
    wrData && !palOpen && selPal
    |=> palette_reg[$past(selIdx[3:0])] ==
        $past(palette_reg[selIdx[3:0]]))
    else $error("palette written while locked");
  a_video_gate: assert property (@(posedge clk_sys) disable iff (reset)
    palOpen |=> !videoEnable && colorIndexBits == RESET_VAL)
    else $error("video not blanked while palette open");
  a_color_top: assert property (@(posedge clk_sys) disable iff (reset)
    !palOpen |=> colorIndexBits[7:6] == $past(colorSelect_reg[3:2]))
    else $error("top color bits wrong");
  a_subst_on: assert property (@(posedge clk_sys) disable iff (reset)
    !palOpen && colSel.substEn
    |=> colorIndexBits[5:4] == $past(colorSelect_reg[1:0]))
    else $error("substitution bits wrong");
  a_subst_off: assert property (@(posedge clk_sys) disable iff (reset)
    !palOpen && !colSel.substEn
    |=> colorIndexBits[5:0] == $past(palette_reg[pixelValue][5:0]))
    else $error("entry bits wrong");
  a_pal_rdback: assert property (@(posedge clk_sys) disable iff (reset)
    rdData_port && selPal && palOpen
    |=> rdValid && rdData == $past(palette_reg[selIdx[3:0]]))
    else $error("palette entry readback wrong");
  a_colsel_rdback: assert property (@(posedge clk_sys) disable iff (reset)
    rdData_port && selIdx == IDX_COLSEL
    |=> rdValid && rdData == $past(colorSelect_reg))
    else $error("color select readback wrong");
  a_hi_idx_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    wrData && !selValid
    |=> $stable(modeControl) && $stable(colorSelect_reg))
    else $error("unmapped index write changed a register");
endmodule : arp_attr_regs

/* hdl/arp_palette_map.sv */
`timescale 1ns/100ps
// combinational color index formation from one palette entry
module arp_palette_map
  import arp_pkg::*;
(
  input  wire logic [5:0] entry,
  input  wire arp_colsel_s sel,
  output logic      [7:0] colorIndex
);
  wire logic [1:0] midBits;

  assign midBits    = sel.substEn ? sel.subst : entry[5:4];
  assign colorIndex = {sel.top, midBits, entry[3:0]};
endmodule : arp_palette_map

/* inc/arp_pkg.sv */
// Summary of operation
// - one shared port reads the index and takes writes as index or data.
// - a separate data read port returns the currently indexed register, except that palette entries read zero while locked.
// - every write to the shared port flips the index/data flip-flop, except in a cycle that also reads input status one.
// - reading input status one forces the flip-flop to the index state.
// - the status address follows emulation: mono or color compatible address.
// - reading the data read port leaves the flip-flop unchanged.
// - index bits 4-0 select attribute register zero through twenty.
// - index bit 5 clear blanks video and opens the palette entries.
// - index bit 5 set enables video and locks the palette entries.
// - sixteen palette entries sit at indexes zero through fifteen.
// - each entry holds six low bits of an 8-bit color index.
// - color index top two bits come from color select bits 3 and 2.
// - mode bit 7 set takes color bits 5 and 4 from color select 1:0.
// - mode bit 7 clear takes color bits 5 and 4 from the entry.
package arp_pkg;
  localparam logic [15:0] PORT_SHARED    = 16'h03c0;
  localparam logic [15:0] PORT_DATA_RD   = 16'h03c1;
  localparam logic [15:0] PORT_STAT_MONO = 16'h03ba;
  localparam logic [15:0] PORT_STAT_CLR  = 16'h03da;
  localparam logic [4:0]  IDX_MODE       = 5'h10;
  localparam logic [4:0]  IDX_BORDER     = 5'h11;
  localparam logic [4:0]  IDX_PLANE      = 5'h12;
  localparam logic [4:0]  IDX_PAN        = 5'h13;
  localparam logic [4:0]  IDX_COLSEL     = 5'h14;
  localparam logic [4:0]  IDX_PAL_LAST   = 5'h0f;
  localparam logic [7:0]  IDX_WR_MASK    = 8'h3f;
  localparam logic [7:0]  PAL_MASK       = 8'h3f;
  localparam int          IDX_VIDEO_BIT  = 5;
  localparam int          MODE_SUBST_BIT = 7;
  localparam logic [7:0]  RESET_VAL      = 8'h00;
  localparam logic [7:0]  READ_ZERO      = 8'h00;

  typedef enum logic {
    FF_INDEX = 1'b0,
    FF_DATA  = 1'b1
  } arp_ff_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } arp_io_s;

  typedef struct packed {
    logic [1:0] top;
    logic [1:0] subst;
    logic       substEn;
  } arp_colsel_s;
endpackage : arp_pkg

/* verif/arp_host_model.sv */
`timescale 1ns/100ps
module arp_host_model
  import arp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rdValid,
  input  wire logic [7:0] rdData,
  output arp_io_s         io
);
  initial io = '0;

  // one access, strobe held across exactly one rising edge
  task automatic cyc(input logic r, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    q = 'x;
    @(negedge clk_sys);
    io = {r, !r, a, d};
    @(negedge clk_sys);
    // released bus shows inverted values so a stale match cannot pass
    io = {1'b0, 1'b0, ~a, ~d};
    for (int n = 0; r && n < 3; n++) begin
      if (rdValid === 1'b1) begin
        q = rdData;
        break;
      end
      @(negedge clk_sys);
    end
  endtask : cyc
endmodule : arp_host_model

/* verif/test_arp_attr_regs.sv */
`timescale 1ns/100ps
module test_arp_attr_regs
  import arp_pkg::*;
;
  logic       clk_sys       = 1'b0;
  logic       reset         = 1'b1;
  logic       monoEmulation = 1'b0;
  logic [3:0] pixelValue    = 4'h5;
  arp_io_s    io;
  logic [7:0] rdData, colorIndexBits, modeControl, borderColor;
  logic [7:0] planeEnable, horizontalPan, q, v;
  logic       rdValid, videoEnable;
  int         err_count       = 0;
  int         samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  arp_host_model host (.clk_sys(clk_sys), .rdValid(rdValid),
                       .rdData(rdData), .io(io));
  arp_attr_regs uut (.clk_sys(clk_sys), .reset(reset), .io(io),
    .monoEmulation(monoEmulation), .pixelValue(pixelValue),
    .rdData(rdData), .rdValid(rdValid), .videoEnable(videoEnable),
    .colorIndexBits(colorIndexBits), .modeControl(modeControl),
    .borderColor(borderColor), .planeEnable(planeEnable),
    .horizontalPan(horizontalPan));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.cyc(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] r);
    host.cyc(1'b1, a, 8'h00, r);
  endtask : rd

  // status read first so the pair always starts in index state
  task automatic setreg(input logic [7:0] i, input logic [7:0] d);
    rd(monoEmulation ? PORT_STAT_MONO : PORT_STAT_CLR, q);
    wr(PORT_SHARED, i);
    wr(PORT_SHARED, d);
  endtask : setreg

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    #50us;
    err_count++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    chk("video", 8'h00, {7'h00, videoEnable});
    chk("color", 8'h00, colorIndexBits);
    setreg(8'h14, 8'h0c);
    rd(PORT_SHARED, v);
    chk("index", 8'h14, v);
    rd(PORT_DATA_RD, v);
    chk("colsel", 8'h0c, v);
    wr(PORT_SHARED, 8'h11);
    rd(PORT_DATA_RD, v);
    rd(PORT_DATA_RD, v);
    wr(PORT_SHARED, 8'h2b);
    chk("border", 8'h2b, borderColor);
    $display("t1 done");
    for (int m = 0; m < 2; m++) begin
      monoEmulation = m[0];
      wr(PORT_SHARED, 8'h12);
      rd(m ? PORT_STAT_CLR : PORT_STAT_MONO, v);
      wr(PORT_SHARED, 8'h07 + 8'(m));
      chk("plane", 8'h07 + 8'(m), planeEnable);
      wr(PORT_SHARED, 8'h12);
      rd(m ? PORT_STAT_MONO : PORT_STAT_CLR, v);
      wr(PORT_SHARED, 8'h13);
      wr(PORT_SHARED, 8'h05 + 8'(m));
      chk("pan", 8'h05 + 8'(m), horizontalPan);
    end
    $display("t2 done");
    for (int i = 0; i < 16; i++)
      setreg(8'(i), 8'hf0 ^ 8'(i));
    for (int i = 0; i < 16; i++) begin
      rd(monoEmulation ? PORT_STAT_MONO : PORT_STAT_CLR, q);
      wr(PORT_SHARED, 8'(i));
      rd(PORT_DATA_RD, v);
      chk("palette", 8'h30 ^ 8'(i), v);
    end
    setreg(8'h15, 8'h55);
    rd(PORT_DATA_RD, v);
    chk("unmapped", 8'h00, v);
    chk("border", 8'h2b, borderColor);
    $display("t3 done");
    setreg(8'h14, 8'h09);
    setreg(8'h30, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("video", 8'h01, {7'h00, videoEnable});
    chk("color", 8'hb5, colorIndexBits);
    setreg(8'h30, 8'h80);
    repeat (2) @(negedge clk_sys);
    chk("mode", 8'h80, modeControl);
    chk("color", 8'h95, colorIndexBits);
    pixelValue = 4'ha;
    repeat (2) @(negedge clk_sys);
    chk("color", 8'h9a, colorIndexBits);
    setreg(8'h25, 8'h00);
    rd(PORT_DATA_RD, v);
    chk("locked", 8'h00, v);
    rd(monoEmulation ? PORT_STAT_MONO : PORT_STAT_CLR, q);
    wr(PORT_SHARED, 8'h05);
    rd(PORT_DATA_RD, v);
    chk("pal5", 8'h35, v);
    chk("video", 8'h00, {7'h00, videoEnable});
    chk("color", 8'h00, colorIndexBits);
    $display("t4 done");
    close_out();
  end
endmodule : test_arp_attr_regs
